// ===== design/dual_period_mode_pkg.sv
// Purpose: shared constants and carriers for the dual period trigger block
// Assumes: one 200 MHz clock, register port with one-cycle read latency
// Notes:   offsets are byte addresses, each register one 32-bit word
package dual_period_mode_pkg;
    // clock and rate figures
    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned MAX_RATE_HZ = 20_000;
    localparam int unsigned DW          = 32;

    // register offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_PRF   = 8'h04;
    localparam logic [7:0] A_PPS   = 8'h08;
    localparam logic [7:0] A_NSAMP = 8'h0c;
    localparam logic [7:0] A_STAT  = 8'h10;
    localparam logic [7:0] A_MASK  = 8'h14;
    localparam logic [7:0] A_RBACK = 8'h18;
    localparam logic [7:0] A_SHORT = 8'h1c;

    // reset values
    localparam logic [31:0] RST_PRF   = 32'h0000_03e8;
    localparam logic [31:0] RST_PPS   = 32'h0000_03e8;
    localparam logic [15:0] RST_NSAMP = 16'h0040;

    // sticky event bits
    localparam int EV_INVALID = 0;
    localparam int EV_RAY     = 1;
    localparam int EV_CLAMP   = 2;
    localparam int EV_W       = 3;

    // readback bits
    localparam int RB_INVALID = 0;
    localparam int RB_RUNNING = 1;

    typedef enum logic [1:0] {
        R_3_2,
        R_4_3,
        R_5_4
    } ratio_e;

    // control word, run in bit 0
    typedef struct packed {
        logic   tseries;
        ratio_e ratio;
        logic   unfold;
        logic   lag2;
        logic   dual;
        logic   run;
    } ctrl_s;
    localparam int CTRL_W = $bits(ctrl_s);

    // trigger side outputs
    typedef struct packed {
        logic ray_low;
        logic ray_end;
        logic use_pair;
        logic ts_first;
        logic lead;
        logic fire;
    } trig_s;

    // long over short period of the selected ratio
    function automatic logic [3:0] ratio_num(ratio_e r);
        case (r)
            R_4_3:   return 4'h4;
            R_5_4:   return 4'h5;
            default: return 4'h3;
        endcase
    endfunction

    function automatic logic [3:0] ratio_den(ratio_e r);
        case (r)
            R_4_3:   return 4'h3;
            R_5_4:   return 4'h4;
            default: return 4'h2;
        endcase
    endfunction
endpackage

// ===== design/dual_period_mode_divider.sv
// Purpose: sequential restoring divider, one quotient bit per clock
// Assumes: start is a one-cycle pulse; inputs held only on that cycle
// Notes:   division by zero yields all ones, which callers clamp away
`timescale 1ns/10ps
`default_nettype none
module dual_period_mode_divider (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    // request
    input  wire logic                    start,
    input  wire logic [dual_period_mode_pkg::DW-1:0] num,
    input  wire logic [dual_period_mode_pkg::DW-1:0] den,
    // answer
    output logic      [dual_period_mode_pkg::DW-1:0] quo,
    output logic                         done
);
    typedef struct packed {
        logic                    busy;
        logic [5:0]              cnt;
        logic [dual_period_mode_pkg::DW:0]   rem;
        logic [dual_period_mode_pkg::DW-1:0] quo;
        logic [dual_period_mode_pkg::DW-1:0] den;
        logic                    done;
    } st_s;

    st_s q;
    st_s next_q;
    logic [dual_period_mode_pkg::DW:0] trial;

    // one shift-subtract step per cycle keeps the area tiny
    always_comb begin
        next_q = q;
        trial = {q.rem[dual_period_mode_pkg::DW-1:0], q.quo[dual_period_mode_pkg::DW-1]};
        next_q.done = 1'b0;
        if (rst) begin
            next_q = '0;
        end else if (start) begin
            next_q.busy = 1'b1;
            next_q.cnt  = 6'(dual_period_mode_pkg::DW);
            next_q.rem  = '0;
            next_q.quo  = num;
            next_q.den  = den;
        end else if (q.busy) begin
            if (trial >= {1'b0, q.den}) begin
                next_q.rem = trial - {1'b0, q.den};
                next_q.quo = {q.quo[dual_period_mode_pkg::DW-2:0], 1'b1};
            end else begin
                next_q.rem = trial;
                next_q.quo = {q.quo[dual_period_mode_pkg::DW-2:0], 1'b0};
            end
            next_q.cnt = q.cnt - 6'h01;
            if (q.cnt == 6'h01) begin
                next_q.busy = 1'b0;
                next_q.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        q <= next_q;
    end

    assign quo  = q.quo;
    assign done = q.done;
endmodule
`default_nettype wire

// ===== design/dual_period_mode_interval.sv
// Purpose: one-shot interval timer, fires len cycles after start
// Assumes: len of at least one; start wins over a fire in the same cycle
// Notes:   fire is combinational so the caller can retrigger without a gap
`timescale 1ns/10ps
`default_nettype none
module dual_period_mode_interval (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    // control
    input  wire logic                    start,
    input  wire logic [dual_period_mode_pkg::DW-1:0] len,
    // expiry
    output logic                         fire
);
    typedef struct packed {
        logic                    busy;
        logic [dual_period_mode_pkg::DW-1:0] cnt;
    } st_s;

    st_s q;
    st_s next_q;

    assign fire = q.busy && (q.cnt == '0);

    // count down from len-1 so the fire lands exactly len cycles on
    always_comb begin
        next_q = q;
        if (rst) begin
            next_q = '0;
        end else if (start) begin
            next_q.busy = 1'b1;
            next_q.cnt  = (len == '0) ? '0 : len - 1'b1;
        end else if (fire) begin
            next_q.busy = 1'b0;
        end else if (q.busy) begin
            next_q.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        q <= next_q;
    end
endmodule
`default_nettype wire

// ===== design/dual_period_mode_trigger.sv
// Purpose: dual period trigger pattern generator with config checking
// Assumes: register port on mclk, read data valid the cycle after rd
// Notes:   periods are worked out by dividers after each rate write
//
// Overview of operation
// - in dual period mode short and long trigger periods alternate
// - time series marks the first pulse of each short pair as first
// - in dual mode only short pairs are flagged usable; long pair data are dropped
// - short period is the reciprocal of requested rate, up to 20 kHz
// - long period comes from the max pulse rate setting, not the host
// - uniform modes treat the bound as a plain maximum pulse rate
// - lag-two moments requested in dual mode flag invalid config
// - odd sample size in dual mode also flags invalid config
// - unfolding varies short period per ray by ratio, duty held
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dual_period_mode_trigger (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    // register port
    input  wire logic [7:0]              addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic      [31:0]             rdata,
    // trigger side
    output dual_period_mode_pkg::trig_s              trig,
    output logic                         irq
);
    typedef enum {
        P_IDLE,
        P_SHORT,
        P_LONG,
        P_UNI
    } phase_e;

    typedef struct packed {
        dual_period_mode_pkg::ctrl_s         ctrl;
        logic [31:0]             prf;
        logic [31:0]             pps;
        logic [15:0]             nsamp;
        logic [dual_period_mode_pkg::EV_W-1:0] status;
        logic [dual_period_mode_pkg::EV_W-1:0] mask;
        logic [31:0]             rdata;
        logic                    irq;
        phase_e                  ph;
        logic [31:0]             len;
        logic [31:0]             cyc;
        logic [15:0]             pcnt;
        logic                    ray_low;
        dual_period_mode_pkg::trig_s         trig;
        logic                    div_go;
        logic                    ok;
        logic [2:0]              got;
        logic [31:0]             hi;
        logic [31:0]             lo;
        logic [31:0]             mx;
        logic                    invalid;
    } st_s;

    st_s q;
    st_s next_q;

    // combinational helpers
    logic [31:0] prf_eff;
    logic [31:0] short_cur;
    logic [31:0] pair;
    logic [31:0] long_len;
    logic [31:0] uni_len;
    logic [31:0] tlen;
    logic        tstart;
    logic        tfire;
    logic [31:0] hq;
    logic [31:0] lq;
    logic [31:0] mq;
    logic        hd;
    logic        ld;
    logic        md;
    logic [dual_period_mode_pkg::EV_W-1:0] ev;
    logic [dual_period_mode_pkg::EV_W-1:0] w1c;

    // rate ceiling
    // requests above the short-only ceiling are held at it; zero is lifted to one
    always_comb begin
        prf_eff = q.prf;
        if (q.prf > dual_period_mode_pkg::MAX_RATE_HZ) begin
            prf_eff = dual_period_mode_pkg::MAX_RATE_HZ;
        end else if (q.prf == '0) begin
            prf_eff = 32'h0000_0001;
        end
    end

    dual_period_mode_divider u_div_hi (
        .mclk  (mclk),
        .rst   (rst),
        .start (q.div_go),
        .num   (dual_period_mode_pkg::CLK_HZ),
        .den   (prf_eff),
        .quo   (hq),
        .done  (hd)
    );

    // stretched short period for low-rate rays
    // low rays run slower than the requested rate so the 20 kHz ceiling still holds
    dual_period_mode_divider u_div_lo (
        .mclk  (mclk),
        .rst   (rst),
        .start (q.div_go),
        .num   (32'(dual_period_mode_pkg::CLK_HZ * dual_period_mode_pkg::ratio_num(q.ctrl.ratio))),
        .den   (32'(prf_eff * dual_period_mode_pkg::ratio_den(q.ctrl.ratio))),
        .quo   (lq),
        .done  (ld)
    );

    // period of the maximum pulse rate setting
    dual_period_mode_divider u_div_mx (
        .mclk  (mclk),
        .rst   (rst),
        .start (q.div_go),
        .num   (dual_period_mode_pkg::CLK_HZ),
        .den   ((q.pps == '0) ? 32'h0000_0001 : q.pps),
        .quo   (mq),
        .done  (md)
    );

    dual_period_mode_interval u_tmr (
        .mclk  (mclk),
        .rst   (rst),
        .start (tstart),
        .len   (tlen),
        .fire  (tfire)
    );

    // long period sum
    // the pair spans two max-rate periods only while that exceeds twice short, so duty holds as short varies; otherwise long equals short
    always_comb begin
        short_cur = (q.ray_low && q.ctrl.unfold) ? q.lo : q.hi;
        pair      = {q.mx[30:0], 1'b0};
        long_len  = (pair > {short_cur[30:0], 1'b0}) ? pair - short_cur : short_cur;
        uni_len   = (q.hi > q.mx) ? q.hi : q.mx;
    end

    // registers, sequencing and status in one next-state process
    always_comb begin
        next_q = q;
        tstart = 1'b0;
        tlen   = short_cur;
        ev     = '0;
        w1c    = '0;
        next_q.trig   = '0;
        next_q.trig.ray_low = q.ray_low;
        next_q.div_go = 1'b0;
        next_q.rdata  = '0;
        // register writes; rate or mode changes restart the period maths
        if (wr) begin
            if (addr == dual_period_mode_pkg::A_CTRL) begin
                next_q.ctrl   = dual_period_mode_pkg::ctrl_s'(wdata[dual_period_mode_pkg::CTRL_W-1:0]);
                next_q.div_go = 1'b1;
                next_q.ph     = P_IDLE;
                // a new run starts a new ray, so ray ends stay on pair boundaries
                next_q.pcnt   = '0;
            end else if (addr == dual_period_mode_pkg::A_PRF) begin
                next_q.prf    = wdata;
                next_q.div_go = 1'b1;
                ev[dual_period_mode_pkg::EV_CLAMP] = (wdata > dual_period_mode_pkg::MAX_RATE_HZ);
            end else if (addr == dual_period_mode_pkg::A_PPS) begin
                next_q.pps    = wdata;
                next_q.div_go = 1'b1;
            end else if (addr == dual_period_mode_pkg::A_NSAMP) begin
                next_q.nsamp  = wdata[15:0];
            end else if (addr == dual_period_mode_pkg::A_STAT) begin
                w1c = wdata[dual_period_mode_pkg::EV_W-1:0];
            end else if (addr == dual_period_mode_pkg::A_MASK) begin
                next_q.mask   = wdata[dual_period_mode_pkg::EV_W-1:0];
            end
        end
        // collect divider answers; a start from idle waits until all three are in
        if (q.div_go) begin
            next_q.ok  = 1'b0;
            next_q.got = '0;
        end else begin
            if (hd) begin
                next_q.hi = hq;
            end
            if (ld) begin
                next_q.lo = lq;
            end
            if (md) begin
                next_q.mx = mq;
            end
            next_q.got = q.got | {md, ld, hd};
            next_q.ok  = &next_q.got;
        end
        next_q.invalid = q.ctrl.dual && (q.ctrl.lag2 || q.nsamp[0]);
        ev[dual_period_mode_pkg::EV_INVALID] = next_q.invalid && !q.invalid;
        // trigger sequencing
        case (q.ph)
            P_IDLE: begin
                if (q.ctrl.run && q.ok && !q.div_go) begin
                    tstart = 1'b1;
                    next_q.trig.fire = 1'b1;
                    if (q.ctrl.dual) begin
                        next_q.trig.lead     = 1'b1;
                        next_q.trig.ts_first = q.ctrl.tseries;
                        next_q.ph = P_SHORT;
                    end else begin
                        tlen = uni_len;
                        next_q.trig.use_pair = 1'b1;
                        next_q.ph = P_UNI;
                    end
                end
            end
            P_SHORT: begin
                if (tfire) begin
                    tstart = 1'b1;
                    tlen   = long_len;
                    next_q.trig.fire     = 1'b1;
                    next_q.trig.use_pair = 1'b1;
                    next_q.ph = P_LONG;
                end
            end
            P_LONG: begin
                if (tfire) begin
                    next_q.ph = P_IDLE;
                    if (q.ctrl.run) begin
                        tstart = 1'b1;
                        next_q.trig.fire     = 1'b1;
                        next_q.trig.lead     = 1'b1;
                        next_q.trig.ts_first = q.ctrl.tseries;
                        next_q.ph = P_SHORT;
                    end
                end
            end
            P_UNI: begin
                if (tfire) begin
                    next_q.ph = P_IDLE;
                    if (q.ctrl.run) begin
                        tstart = 1'b1;
                        tlen   = uni_len;
                        next_q.trig.fire     = 1'b1;
                        next_q.trig.use_pair = 1'b1;
                        next_q.ph = P_UNI;
                    end
                end
            end
            default: begin
                next_q.ph = P_IDLE;
            end
        endcase
        // ray bookkeeping; an even sample size ends rays after a long-pulse trigger
        if (next_q.trig.fire) begin
            next_q.cyc = 32'h0000_0001;
            if (q.pcnt + 16'h0001 >= q.nsamp) begin
                next_q.pcnt = '0;
                next_q.trig.ray_end = 1'b1;
                ev[dual_period_mode_pkg::EV_RAY] = 1'b1;
                next_q.ray_low = q.ray_low ^ (q.ctrl.unfold && q.ctrl.dual);
            end else begin
                next_q.pcnt = q.pcnt + 16'h0001;
            end
        end else begin
            next_q.cyc = q.cyc + 32'h0000_0001;
        end
        if (tstart) begin
            next_q.len = tlen;
        end
        // set beats clear for events landing on a clearing write
        next_q.status = (q.status & ~w1c) | ev;
        next_q.irq = |(next_q.status & next_q.mask);
        // read data stand only in the cycle after the strobe
        if (rd) begin
            if (addr == dual_period_mode_pkg::A_CTRL) begin
                next_q.rdata = 32'(q.ctrl);
            end else if (addr == dual_period_mode_pkg::A_PRF) begin
                next_q.rdata = q.prf;
            end else if (addr == dual_period_mode_pkg::A_PPS) begin
                next_q.rdata = q.pps;
            end else if (addr == dual_period_mode_pkg::A_NSAMP) begin
                next_q.rdata = 32'(q.nsamp);
            end else if (addr == dual_period_mode_pkg::A_STAT) begin
                next_q.rdata = 32'(q.status);
            end else if (addr == dual_period_mode_pkg::A_MASK) begin
                next_q.rdata = 32'(q.mask);
            end else if (addr == dual_period_mode_pkg::A_RBACK) begin
                next_q.rdata[dual_period_mode_pkg::RB_INVALID] = q.invalid;
                next_q.rdata[dual_period_mode_pkg::RB_RUNNING] = (q.ph != P_IDLE);
            end else if (addr == dual_period_mode_pkg::A_SHORT) begin
                next_q.rdata = short_cur;
            end
        end
        if (rst) begin
            next_q = '0;
            next_q.prf    = dual_period_mode_pkg::RST_PRF;
            next_q.pps    = dual_period_mode_pkg::RST_PPS;
            next_q.nsamp  = dual_period_mode_pkg::RST_NSAMP;
            next_q.div_go = 1'b1;
            next_q.ph     = P_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        q <= next_q;
    end

    // outputs straight from the state flops
    assign rdata = q.rdata;
    assign trig  = q.trig;
    assign irq   = q.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_period_len: assert property (
        tfire && q.ph != P_IDLE |-> q.cyc == q.len)
        else $error("trigger interval differs from loaded period");

    chk_alternate_lead: assert property (
        q.ph == P_SHORT && tfire |=> q.trig.fire && !q.trig.lead && q.ph == P_LONG)
        else $error("short period not followed by long pulse");

    chk_lead_first: assert property (
        q.trig.ts_first |-> q.trig.fire && q.trig.lead && q.ph == P_SHORT)
        else $error("time series first marker off a short lead pulse");

    chk_long_dropped: assert property (
        q.trig.fire && q.trig.lead |-> !q.trig.use_pair)
        else $error("long pair flagged usable");

    chk_rate_cap: assert property (
        q.prf > dual_period_mode_pkg::MAX_RATE_HZ |-> prf_eff == dual_period_mode_pkg::MAX_RATE_HZ)
        else $error("requested rate not held at ceiling");

    chk_long_floor: assert property (
        q.ph == P_SHORT && tfire |=> q.len >= $past(short_cur) && q.ph == P_LONG)
        else $error("long period shorter than short period");

    chk_duty_const: assert property (
        q.ph == P_SHORT && tfire && pair > {short_cur[30:0], 1'b0}
        |=> q.len + $past(short_cur) == $past(pair))
        else $error("short plus long does not span two max periods");

    chk_uniform_bound: assert property (
        q.ph == P_UNI && tfire && q.ctrl.run |=> q.len >= $past(q.mx) && q.len >= $past(q.hi))
        else $error("uniform period below max rate period");

    chk_lag2_flag: assert property (
        q.ctrl.dual && q.ctrl.lag2 && !$changed(q.ctrl) |=> q.invalid)
        else $error("lag-two in dual mode not flagged");

    chk_odd_flag: assert property (
        q.ctrl.dual && q.nsamp[0] && $stable(q.nsamp) && $stable(q.ctrl) |=> q.invalid)
        else $error("odd sample size in dual mode not flagged");
endmodule
`default_nettype wire

// ===== sim/dual_period_mode_tx_model.sv
// Purpose: transmitter side of the trigger link, records each trigger it receives
// Assumes: fire is a one-cycle pulse on mclk, other fields qualify it
// Notes:   the first gap after reset is meaningless, later gaps are exact
`timescale 1ns/10ps
`default_nettype none
module dual_period_mode_tx_model (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // trigger from the block
    input  wire dual_period_mode_pkg::trig_s trig,
    // what the transmitter saw
    output var int               fires,
    output var int               gap,
    output var dual_period_mode_pkg::trig_s  seen
);
    int cnt;

    // gap counts edges from one fire to the next, so S cycles read as S
    always @(posedge mclk) begin
        if (rst) begin
            fires <= 0;
            gap   <= 0;
            cnt   <= 0;
            seen  <= '0;
        end else begin
            cnt <= cnt + 1;
            if (trig.fire) begin
                fires <= fires + 1;
                gap   <= cnt;
                cnt   <= 1;
                seen  <= trig;
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_dual_period_mode_trigger.sv
// Purpose: self-checking bench for the dual period trigger block
// Assumes: register port with one-cycle read latency, 200 MHz mclk
// Notes:   rates chosen so one short plus one long interval fit the run
`timescale 1ns/10ps
`default_nettype none
module tb_dual_period_mode_trigger;
    localparam int S_CYC = dual_period_mode_pkg::CLK_HZ / dual_period_mode_pkg::MAX_RATE_HZ;
    localparam int M_CYC = dual_period_mode_pkg::CLK_HZ / 12500;
    localparam int L_CYC = 2 * M_CYC - S_CYC;
    localparam int LO_CYC = S_CYC * 3 / 2;

    logic            mclk;
    logic            rst;
    logic [7:0]      addr;
    logic [31:0]     wdata;
    logic            wr;
    logic            rd;
    logic [31:0]     rdata;
    dual_period_mode_pkg::trig_s trig;
    logic            irq;
    int              fires;
    int              gap;
    dual_period_mode_pkg::trig_s seen;
    int              bad_count;
    int              num_checks;
    int              base;
    logic [31:0]     rv;
    logic [7:0]      t_addr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
    logic [31:0]     t_exp  [8] = '{32'h0, dual_period_mode_pkg::RST_PRF, dual_period_mode_pkg::RST_PPS,
                                    {16'h0, dual_period_mode_pkg::RST_NSAMP}, 32'h0, 32'h0, 32'h0, 32'h0};

    dual_period_mode_trigger dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                      .rdata(rdata), .trig(trig), .irq(irq));

    dual_period_mode_tx_model tx (.mclk(mclk), .rst(rst), .trig(trig), .fires(fires), .gap(gap),
                      .seen(seen));

    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // bounded wait for the transmitter to count n triggers
    task automatic wait_fires(input int n);
        int k;
        k = 0;
        while (fires < n && k < 40000) begin
            @(posedge mclk);
            k++;
        end
        #1;
        if (fires < n) begin
            bad_count++;
            $display("Error fire count expected %0d seen %0d", n, fires);
            give_verdict();
        end
    endtask

    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
        bad_count = 0; num_checks = 0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        // reset values, unmapped address reads zero
        for (int i = 0; i < 8; i++) begin
            rd_reg(t_addr[i], rv);
            chk("reset value", rv, t_exp[i]);
        end
        $display("test reset values done");
        // configuration checks and interrupt path
        wr_reg(dual_period_mode_pkg::A_MASK, 32'h1);
        wr_reg(dual_period_mode_pkg::A_NSAMP, 32'h2);
        wr_reg(dual_period_mode_pkg::A_CTRL, 32'h6);
        repeat (3) @(posedge mclk);
        rd_reg(dual_period_mode_pkg::A_RBACK, rv);
        chk("lag two in dual", rv, 32'h1);
        chk("irq raised", {31'h0, irq}, 32'h1);
        wr_reg(dual_period_mode_pkg::A_STAT, 32'h1);
        rd_reg(dual_period_mode_pkg::A_STAT, rv);
        chk("status cleared", rv, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr_reg(dual_period_mode_pkg::A_NSAMP, 32'h3);
        wr_reg(dual_period_mode_pkg::A_CTRL, 32'h2);
        repeat (3) @(posedge mclk);
        rd_reg(dual_period_mode_pkg::A_RBACK, rv);
        chk("odd sample size", rv, 32'h1);
        wr_reg(dual_period_mode_pkg::A_NSAMP, 32'h2);
        repeat (3) @(posedge mclk);
        rd_reg(dual_period_mode_pkg::A_RBACK, rv);
        chk("even sample size", rv, 32'h0);
        $display("test configuration done");
        // host sets the pulse bound once and never overwrites it
        wr_reg(dual_period_mode_pkg::A_PPS, 32'd12500);
        wr_reg(dual_period_mode_pkg::A_STAT, 32'h7);
        wr_reg(dual_period_mode_pkg::A_PRF, 32'd40000);
        repeat (60) @(posedge mclk);
        rd_reg(dual_period_mode_pkg::A_STAT, rv);
        chk("rate above limit", rv, 32'h4);
        rd_reg(dual_period_mode_pkg::A_SHORT, rv);
        chk("short period", rv, 32'(S_CYC));
        // dual period run with time series marking
        base = fires;
        wr_reg(dual_period_mode_pkg::A_CTRL, 32'h43);
        wait_fires(base + 1);
        chk("first lead", {29'h0, seen.lead, seen.ts_first, seen.use_pair}, 32'h6);
        wait_fires(base + 2);
        chk("short gap", 32'(gap), 32'(S_CYC));
        chk("pair closes", {29'h0, seen.lead, seen.use_pair, seen.ray_end}, 32'h3);
        wait_fires(base + 3);
        chk("long gap", 32'(gap), 32'(L_CYC));
        chk("long then lead", {31'h0, seen.lead}, 32'h1);
        rd_reg(dual_period_mode_pkg::A_STAT, rv);
        chk("ray end event", rv, 32'h6);
        rd_reg(dual_period_mode_pkg::A_RBACK, rv);
        chk("running", rv, 32'h2);
        $display("test dual period done");
        // uniform triggers use the bound as a plain rate cap
        base = fires;
        wr_reg(dual_period_mode_pkg::A_CTRL, 32'h1);
        wait_fires(base + 2);
        chk("uniform gap", 32'(gap), 32'(M_CYC));
        chk("uniform flags", {30'h0, seen.lead, seen.use_pair}, 32'h1);
        wr_reg(dual_period_mode_pkg::A_CTRL, 32'h0);
        $display("test uniform done");
        // unfolding at 3:2; the ray ending on the second pulse switches to the slow short
        base = fires;
        wr_reg(dual_period_mode_pkg::A_CTRL, 32'h0b);
        wait_fires(base + 2);
        chk("unfold gap", 32'(gap), 32'(S_CYC));
        chk("unfold ray end", {31'h0, seen.ray_end}, 32'h1);
        rd_reg(dual_period_mode_pkg::A_SHORT, rv);
        chk("low ray short", rv, 32'(LO_CYC));
        chk("low ray flag", {31'h0, trig.ray_low}, 32'h1);
        wr_reg(dual_period_mode_pkg::A_CTRL, 32'h0);
        $display("test unfold done");
        give_verdict();
    end
endmodule
`default_nettype wire
